// ==== core/xlat_check_defines.svh ====
`ifndef XLAT_CHECK_DEFINES_SVH
`define XLAT_CHECK_DEFINES_SVH

// bus geometry
`define ADDR_W          8
`define DATA_W          32
`define WORD_W          16
`define BYTE_W          8

// register byte offsets
`define REG_CTRL        8'h00
`define REG_PTR         8'h04
`define REG_BASE        8'h08
`define REG_TALLY       8'h0C
`define REG_FLAGS       8'h10
`define REG_PC          8'h14
`define REG_SAVED_PC    8'h18
`define REG_STATUS      8'h1C
`define REG_WORD1       8'h20

// control fields
`define CTRL_START_BIT  0
`define CTRL_VAR_LSB    1
`define CTRL_VAR_MSB    2

// flag byte layout
`define FLAG_C          7
`define FLAG_Z          6
`define FLAG_S          5
`define FLAG_V          4
`define FLAG_D          3
`define FLAG_H          2

// status fields
`define STAT_BUSY       0
`define STAT_INTR       1

// reset values
`define RST_WORD        16'h0000
`define RST_BYTE        8'h00

// timing in clock cycles
`define CNT_W           4
`define SETUP_CYC       4'hB
`define STEP_CYC        4'hE
`define INT_CYC         4'h7
`define CNT_ONE         4'h1
`define CNT_ZERO        4'h0

// responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== core/xlat_check_pkg.sv ====
package xlat_check_pkg;

    typedef enum logic [1:0] {
        xlat_check_up_single,
        xlat_check_up_repeat,
        xlat_check_down_repeat,
        variant_spare
    } variant_type;

    typedef enum logic [1:0] {
        st_idle,
        st_setup,
        st_step,
        st_int
    } state_type;

endpackage : xlat_check_pkg

// ==== core/fetch_if.sv ====
`timescale 1ns/10ps
`include "xlat_check_defines.svh"

interface fetch_if;
    logic                 req;
    logic [`WORD_W-1:0]   addr;
    logic                 done;
    logic [`BYTE_W-1:0]   data;

    modport requester (output req, output addr, input done, input data);
    modport server    (input req, input addr, output done, output data);
endinterface : fetch_if

// ==== core/byte_fetcher.sv ====
`timescale 1ns/10ps
`include "xlat_check_defines.svh"

module byte_fetcher (
    // clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // engine side
    fetch_if.server                  fetch,
    // memory read port
    output      logic                mem_rd_req,
    output      logic [`WORD_W-1:0]  mem_addr,
    input  wire logic [`BYTE_W-1:0]  mem_rdata,
    input  wire logic                mem_rvalid
);

    ////////////////////////////////////////////////////////////////////////
    // read-only port: no write strobe exists, string and table stay intact [RQ9]
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mem_rd_req <= 1'b0;
        else if (fetch.req)
            mem_rd_req <= 1'b1;
        else if (mem_rvalid)
            mem_rd_req <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mem_addr <= `RST_WORD;
        else if (fetch.req)
            mem_addr <= fetch.addr;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fetch.data <= `RST_BYTE;
        else if (mem_rd_req && mem_rvalid)
            fetch.data <= mem_rdata;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            fetch.done <= 1'b0;
        else
            fetch.done <= mem_rd_req && mem_rvalid;
    end

endmodule : byte_fetcher

// ==== core/xlat_check_unit.sv ====
// Operation
// RQ1: after each step Z is set when translated byte is zero; C,S,D,H untouched.
// RQ2: after each step V is set when the decremented tally is zero.
// RQ3: repeating forms take 11 cycles plus 14 per byte tested.
// RQ4: repeating forms take interrupts only at a step boundary.
// RQ5: the start-of-instruction program counter is saved before an interrupt.
// RQ6: each accepted interrupt adds seven cycles.
// RQ7: table address is base plus target byte zero-extended, wrapping.
// RQ8: the table byte is written to the high byte of word register one.
// RQ9: string and table memory are only ever read.
// RQ10: increment variants add one to the string pointer after the fetch.
// RQ11: after the pointer update every variant decrements the tally.
// RQ12: repeat until a nonzero translation or the tally reaches zero.
// RQ13: 1 to 65536 bytes; a zero tally wraps to the maximum.
// RQ14: the decrement variant subtracts one from the string pointer.
// RQ15: at an interrupt boundary all registers reflect completed steps exactly.
// RQ16: the table base register is never changed by the instruction.
`timescale 1ns/10ps
`include "xlat_check_defines.svh"

module xlat_check_unit (
    // clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // axi4-lite write
    input  wire logic [`ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output      logic                s_axi_awready,
    input  wire logic [`DATA_W-1:0]  s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output      logic                s_axi_wready,
    output      logic [1:0]          s_axi_bresp,
    output      logic                s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // axi4-lite read
    input  wire logic [`ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output      logic                s_axi_arready,
    output      logic [`DATA_W-1:0]  s_axi_rdata,
    output      logic [1:0]          s_axi_rresp,
    output      logic                s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // memory read port
    output      logic                mem_rd_req,
    output      logic [`WORD_W-1:0]  mem_addr,
    input  wire logic [`BYTE_W-1:0]  mem_rdata,
    input  wire logic                mem_rvalid,
    // interrupt boundary
    input  wire logic                irq_req,
    output      logic                irq_ack,
    output      logic                busy
);

    fetch_if fetch ();

    byte_fetcher u_fetch (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .fetch      (fetch.server),
        .mem_rd_req (mem_rd_req),
        .mem_addr   (mem_addr),
        .mem_rdata  (mem_rdata),
        .mem_rvalid (mem_rvalid)
    );

    function automatic logic [`WORD_W-1:0] addr_add(input logic [`WORD_W-1:0] a,
                                                    input logic [`WORD_W-1:0] d);
        addr_add = a + d;
    endfunction : addr_add

    function automatic logic [`WORD_W-1:0] merge16(input logic [`WORD_W-1:0] old,
                                                   input logic [`DATA_W-1:0] wd,
                                                   input logic [3:0]         st);
        merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    endfunction : merge16

    ////////////////////////////////////////////////////////////////////////
    // architectural state
    xlat_check_pkg::state_type    state_r;
    xlat_check_pkg::variant_type  variant_r;
    logic [`CNT_W-1:0]            cyc_r;
    logic [`WORD_W-1:0]           ptr_r;
    logic [`WORD_W-1:0]           base_r;
    logic [`WORD_W-1:0]           tally_r;
    logic [`WORD_W-1:0]           pc_r;
    logic [`WORD_W-1:0]           saved_pc_r;
    logic [`BYTE_W-1:0]           flags_r;
    logic [`BYTE_W-1:0]           xbyte_r;
    logic [`BYTE_W-1:0]           low1_r;
    logic [`BYTE_W-1:0]           new_r;
    logic                         tgt_got_r;
    logic                         tbl_got_r;
    logic                         intr_r;

    // bus state
    logic                         aw_held_r;
    logic                         w_held_r;
    logic [`ADDR_W-1:0]           awaddr_r;
    logic [`DATA_W-1:0]           wdata_r;
    logic [3:0]                   wstrb_r;

    logic                         wr_go;
    logic                         wr_hit;
    logic                         start_go;
    logic                         step_done;
    logic                         stop_now;
    logic [`WORD_W-1:0]           tally_dec;

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
    assign wr_go         = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_hit        = (awaddr_r == `REG_CTRL) || (awaddr_r == `REG_PTR)
                        || (awaddr_r == `REG_BASE) || (awaddr_r == `REG_TALLY)
                        || (awaddr_r == `REG_FLAGS) || (awaddr_r == `REG_PC)
                        || (awaddr_r == `REG_WORD1);
    // engine owns its registers while running, so bus writes then are dropped
    assign start_go = wr_go && !busy && (awaddr_r == `REG_CTRL)
                   && wstrb_r[0] && wdata_r[`CTRL_START_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            awaddr_r  <= `RST_BYTE;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
        end
        else if (wr_go)
            aw_held_r <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_r <= 1'b0;
            wdata_r  <= {`DATA_W{1'b0}};
            wstrb_r  <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
        end
        else if (wr_go)
            w_held_r <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= {`DATA_W{1'b0}};
            s_axi_rresp  <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            case (s_axi_araddr)
                `REG_CTRL:     s_axi_rdata <= {29'h0, variant_r, 1'b0};
                `REG_PTR:      s_axi_rdata <= {16'h0, ptr_r};
                `REG_BASE:     s_axi_rdata <= {16'h0, base_r};
                `REG_TALLY:    s_axi_rdata <= {16'h0, tally_r};
                `REG_FLAGS:    s_axi_rdata <= {24'h0, flags_r};
                `REG_PC:       s_axi_rdata <= {16'h0, pc_r};
                `REG_SAVED_PC: s_axi_rdata <= {16'h0, saved_pc_r};
                `REG_STATUS:   s_axi_rdata <= {30'h0, intr_r, busy};
                `REG_WORD1:    s_axi_rdata <= {16'h0, xbyte_r, low1_r};
                default:
                begin
                    s_axi_rdata <= {`DATA_W{1'b0}};
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencing
    assign busy      = (state_r != xlat_check_pkg::st_idle);
    // a step closes only at its last cycle, so registers never show half a step [RQ4]
    assign step_done = (state_r == xlat_check_pkg::st_step)
                    && (cyc_r == `STEP_CYC - `CNT_ONE) && tbl_got_r;
    assign tally_dec = addr_add(tally_r, 16'hFFFF); // zero wraps to FFFF [RQ13]
    assign stop_now  = (variant_r == xlat_check_pkg::xlat_check_up_single)
                    || (new_r != `RST_BYTE) || (tally_dec == `RST_WORD); // [RQ12]
    assign irq_ack   = step_done && !stop_now && irq_req; // [RQ4]

    // fetch issue: target at step start, table as soon as target returns
    assign fetch.req  = ((state_r == xlat_check_pkg::st_step) && (cyc_r == `CNT_ZERO))
                     || (fetch.done && !tgt_got_r);
    assign fetch.addr = (cyc_r == `CNT_ZERO) ? ptr_r
                      : addr_add(base_r, {8'h00, fetch.data}); // [RQ7]

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= xlat_check_pkg::st_idle;
            cyc_r   <= `CNT_ZERO;
        end
        else
        begin
            case (state_r)
                xlat_check_pkg::st_idle:
                begin
                    cyc_r <= `CNT_ZERO;
                    if (start_go)
                        state_r <= xlat_check_pkg::st_setup;
                end
                xlat_check_pkg::st_setup:
                begin
                    cyc_r <= cyc_r + `CNT_ONE;
                    if (cyc_r == `SETUP_CYC - `CNT_ONE) // [RQ3]
                    begin
                        cyc_r   <= `CNT_ZERO;
                        state_r <= xlat_check_pkg::st_step;
                    end
                end
                xlat_check_pkg::st_step:
                begin
                    // slow memory stalls at the last cycle rather than losing a byte
                    if (cyc_r != `STEP_CYC - `CNT_ONE)
                        cyc_r <= cyc_r + `CNT_ONE;
                    if (step_done) // [RQ3]
                    begin
                        cyc_r <= `CNT_ZERO;
                        if (stop_now)
                            state_r <= xlat_check_pkg::st_idle;
                        else if (irq_req)
                            state_r <= xlat_check_pkg::st_int;
                    end
                end
                xlat_check_pkg::st_int:
                begin
                    cyc_r <= cyc_r + `CNT_ONE;
                    if (cyc_r == `INT_CYC - `CNT_ONE) // [RQ6]
                        state_r <= xlat_check_pkg::st_idle;
                end
                default:
                begin
                    state_r <= xlat_check_pkg::st_idle;
                    cyc_r   <= `CNT_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tgt_got_r <= 1'b0;
            tbl_got_r <= 1'b0;
            new_r     <= `RST_BYTE;
        end
        else if (fetch.req && (cyc_r == `CNT_ZERO))
        begin
            tgt_got_r <= 1'b0;
            tbl_got_r <= 1'b0;
        end
        else if (fetch.done && !tgt_got_r)
            tgt_got_r <= 1'b1;
        else if (fetch.done && !tbl_got_r)
        begin
            tbl_got_r <= 1'b1;
            new_r     <= fetch.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // programmer-visible registers, all updated together at step close [RQ15]
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ptr_r   <= `RST_WORD;
            tally_r <= `RST_WORD;
            flags_r <= `RST_BYTE;
            xbyte_r <= `RST_BYTE;
            low1_r  <= `RST_BYTE;
        end
        else if (step_done)
        begin
            xbyte_r <= new_r; // [RQ8]
            flags_r[`FLAG_Z] <= (new_r == `RST_BYTE); // [RQ1]
            flags_r[`FLAG_V] <= (tally_dec == `RST_WORD); // [RQ2]
            tally_r <= tally_dec; // [RQ11]
            if (variant_r == xlat_check_pkg::xlat_check_down_repeat)
                ptr_r <= addr_add(ptr_r, 16'hFFFF); // [RQ14]
            else
                ptr_r <= addr_add(ptr_r, 16'h0001); // [RQ10]
        end
        else if (wr_go && !busy)
        begin
            case (awaddr_r)
                `REG_PTR:   ptr_r   <= merge16(ptr_r, wdata_r, wstrb_r);
                `REG_TALLY: tally_r <= merge16(tally_r, wdata_r, wstrb_r);
                `REG_FLAGS: flags_r <= wstrb_r[0] ? wdata_r[7:0] : flags_r;
                `REG_WORD1: {xbyte_r, low1_r} <= merge16({xbyte_r, low1_r}, wdata_r, wstrb_r);
                default:    ptr_r   <= ptr_r;
            endcase
        end
    end

    // base is loaded only by software while idle, never by the engine [RQ16]
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            base_r    <= `RST_WORD;
            pc_r      <= `RST_WORD;
            variant_r <= xlat_check_pkg::xlat_check_up_single;
        end
        else if (wr_go && !busy)
        begin
            if (awaddr_r == `REG_BASE)
                base_r <= merge16(base_r, wdata_r, wstrb_r);
            if (awaddr_r == `REG_PC)
                pc_r <= merge16(pc_r, wdata_r, wstrb_r);
            if (start_go)
                variant_r <= xlat_check_pkg::variant_type'(
                             wdata_r[`CTRL_VAR_MSB:`CTRL_VAR_LSB]);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            saved_pc_r <= `RST_WORD;
            intr_r     <= 1'b0;
        end
        else if (irq_ack)
        begin
            saved_pc_r <= pc_r; // [RQ5]
            intr_r     <= 1'b1;
        end
        else if (start_go)
            intr_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // own tally of setup cycles, so the check does not lean on cyc_r
    logic [`CNT_W-1:0]            setup_seen_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            setup_seen_r <= `CNT_ZERO;
        else if (state_r == xlat_check_pkg::st_setup)
            setup_seen_r <= setup_seen_r + `CNT_ONE;
        else
            setup_seen_r <= `CNT_ZERO;
    end

    // counter restarts on any gap, so reaching the count proves an unbroken run
    sequence s_setup_run;
        (state_r == xlat_check_pkg::st_setup) ##10
        ((state_r == xlat_check_pkg::st_setup)
         && (setup_seen_r == `SETUP_CYC - `CNT_ONE));
    endsequence
    sequence s_int_run;
        (state_r == xlat_check_pkg::st_int) [*7];
    endsequence

    property p_zero_flag;
        step_done |=> flags_r[`FLAG_Z] == (xbyte_r == `RST_BYTE)
                      && $stable(flags_r[`FLAG_C]) && $stable(flags_r[`FLAG_S]);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong"); // [RQ1]

    property p_ovf_flag;
        step_done |=> flags_r[`FLAG_V] == (tally_r == `RST_WORD);
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag wrong"); // [RQ2]

    property p_setup_time;
        start_go |=> s_setup_run ##1 (state_r == xlat_check_pkg::st_step);
    endproperty
    a_setup_time: assert property (p_setup_time) else $error("setup not 11"); // [RQ3]

    property p_step_time;
        step_done |-> $past(state_r == xlat_check_pkg::st_step, 13);
    endproperty
    a_step_time: assert property (p_step_time) else $error("step shorter than 14"); // [RQ3]

    property p_int_time;
        irq_ack |=> s_int_run ##1 (state_r == xlat_check_pkg::st_idle && intr_r);
    endproperty
    a_int_time: assert property (p_int_time) else $error("interrupt not 7"); // [RQ6]

    property p_saved_pc;
        irq_ack |=> saved_pc_r == $past(pc_r);
    endproperty
    a_saved_pc: assert property (p_saved_pc) else $error("pc not saved"); // [RQ5]

    property p_ptr_step;
        step_done |=> ptr_r == ((variant_r == xlat_check_pkg::xlat_check_down_repeat)
                      ? $past(ptr_r) - 16'h0001 : $past(ptr_r) + 16'h0001);
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer step wrong"); // [RQ10]

    property p_tally_dec;
        step_done |=> tally_r == $past(tally_r) - 16'h0001;
    endproperty
    a_tally_dec: assert property (p_tally_dec) else $error("tally not decremented"); // [RQ11]

    property p_base_hold;
        busy |=> $stable(base_r);
    endproperty
    a_base_hold: assert property (p_base_hold) else $error("base changed"); // [RQ16]

    property p_stop;
        step_done && stop_now |=> !busy;
    endproperty
    a_stop: assert property (p_stop) else $error("scan did not stop"); // [RQ12]

endmodule : xlat_check_unit

// ==== testbench/mem_model.sv ====
`timescale 1ns/10ps
module mem_model (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // read port
    input  wire logic        mem_rd_req,
    input  wire logic [15:0] mem_addr,
    output      logic [7:0]  mem_rdata,
    output      logic        mem_rvalid,
    // answer delay
    input  wire logic [3:0]  lag
);
    logic [7:0] mem [0:65535];
    logic [3:0] wait_r;
    initial
    begin
        foreach (mem[i]) mem[i] = 8'h00;
    end
    // data scrambles between answers so a stale byte never passes
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !mem_rd_req || mem_rvalid)
        begin
            wait_r <= 4'h0;
            mem_rvalid <= 1'h0;
            mem_rdata <= aresetn ? ~mem_rdata : 8'h5A;
        end
        else if (wait_r == lag)
        begin
            mem_rvalid <= 1'h1;
            mem_rdata <= mem[mem_addr];
        end
        else
            wait_r <= wait_r + 4'h1;
    end
endmodule : mem_model

// ==== testbench/xlat_check_unit_tb.sv ====
`timescale 1ns/10ps
`include "xlat_check_defines.svh"
module xlat_check_unit_tb;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, mem_rdata;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF, lag = 4'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, irq_req = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, mem_rd_req, mem_rvalid, irq_ack, busy;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] mem_addr;
    int          failures = 0, n_checks = 0, busy_n = 0, ack_n = 0, nb;
    always #5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        if (busy === 1'h1) busy_n++;
        if (irq_ack === 1'h1) ack_n++;
    end
    xlat_check_unit dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_rd_req,
        .mem_addr, .mem_rdata, .mem_rvalid, .irq_req, .irq_ack, .busy);
    mem_model mem_u (.aclk, .aresetn, .mem_rd_req, .mem_addr, .mem_rdata, .mem_rvalid, .lag);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic tmo();
        failures++;
        end_of_test();
    endtask : tmo
    // ready sampled at the falling edge, valid released after the rising one
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        b = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int i = 0; i < 50 && !b; i++)
        begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        @(posedge aclk);
        if (!b) tmo();
    endtask : axw
    task automatic axr(input logic [7:0] a);
        logic ar, r;
        r = 1'h0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int i = 0; i < 50 && !r; i++)
        begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h0;
        @(posedge aclk);
        if (!r) tmo();
    endtask : axr
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        axr(a);
        chk(nm, rd, exp);
    endtask : rchk
    task automatic load(input logic [15:0] p, input logic [15:0] b, input logic [15:0] t);
        axw(`REG_PTR, {16'h0, p});
        axw(`REG_BASE, {16'h0, b});
        axw(`REG_TALLY, {16'h0, t});
    endtask : load
    task automatic go(input xlat_check_pkg::variant_type v);
        int b0;
        b0 = busy_n;
        axw(`REG_CTRL, {29'h0, v, 1'h1});
        for (int i = 0; i < 3000 && busy !== 1'h0; i++) @(negedge aclk);
        if (busy !== 1'h0) tmo();
        nb = busy_n - b0;
        @(posedge aclk);
    endtask : go
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rchk("ptr reset", `REG_PTR, 32'h0);
        axw(8'h40, 32'h1);
        chk("bresp", resp, `RESP_SLVERR);
        rchk("unmapped", 8'h40, 32'h0);
        chk("rresp", resp, `RESP_SLVERR);
    endtask : t_regs
    task automatic t_down();
        mem_u.mem[16'h4001] = 8'h40;
        mem_u.mem[16'h4002] = 8'h80;
        mem_u.mem[16'h1040] = 8'h40;
        load(16'h4002, 16'h1000, 16'h0003);
        go(xlat_check_pkg::xlat_check_down_repeat);
        chk("busy", nb, 11 + 14 * 2);
        rchk("word1", `REG_WORD1, 32'h4000);
        rchk("ptr", `REG_PTR, 32'h4000);
        rchk("tally", `REG_TALLY, 32'h1);
        rchk("flags", `REG_FLAGS, 32'h0);
        rchk("base", `REG_BASE, 32'h1000);
    endtask : t_down
    // slow memory: results only, the step may stall
    task automatic t_single();
        lag <= 4'h6;
        mem_u.mem[16'h3000] = 8'h07;
        load(16'h3000, 16'h1000, 16'h0001);
        axw(`REG_FLAGS, 32'hAC);
        go(xlat_check_pkg::xlat_check_up_single);
        lag <= 4'h0;
        rchk("ptr", `REG_PTR, 32'h3001);
        rchk("tally", `REG_TALLY, 32'h0);
        rchk("flags", `REG_FLAGS, 32'hFC);
        rchk("word1", `REG_WORD1, 32'h0);
    endtask : t_single
    task automatic t_irq();
        int a0;
        mem_u.mem[16'h2000] = 8'h20;
        mem_u.mem[16'h2001] = 8'h21;
        mem_u.mem[16'h0011] = 8'h05;
        axw(`REG_PC, 32'h1234);
        load(16'h2000, 16'hFFF0, 16'h0000);
        a0 = ack_n;
        irq_req <= 1'h1;
        go(xlat_check_pkg::xlat_check_up_repeat);
        irq_req <= 1'h0;
        chk("busy", nb, 11 + 14 + 7);
        chk("acks", ack_n - a0, 32'h1);
        rchk("saved pc", `REG_SAVED_PC, 32'h1234);
        rchk("status", `REG_STATUS, 32'h2);
        rchk("ptr", `REG_PTR, 32'h2001);
        rchk("tally", `REG_TALLY, 32'hFFFF);
        rchk("flags", `REG_FLAGS, 32'hEC);
        go(xlat_check_pkg::xlat_check_up_repeat);
        chk("busy", nb, 11 + 14);
        rchk("word1", `REG_WORD1, 32'h0500);
        rchk("ptr", `REG_PTR, 32'h2002);
        rchk("tally", `REG_TALLY, 32'hFFFE);
        rchk("flags", `REG_FLAGS, 32'hAC);
    endtask : t_irq
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_regs();
        t_down();
        t_single();
        t_irq();
        end_of_test();
    end
endmodule : xlat_check_unit_tb
